//--- hdl/sft_ctrl.sv
/*
 * Receive and transmit FIFO control for one serial channel: FIFO clear,
 * threshold selection, interrupt conditions and register port.
 * Assumes the frame engine pushes received bytes and pops bytes to send,
 * all synchronous to clk.
 */
// Summary of operation
// - Writing one to rx clear empties rx FIFO, level zero, read pointer reset.
// - Rx interrupt on reaching threshold; optionally also on read leaving level above.
// - Rx threshold codes: half duplex 4,1,2,3 bytes; full duplex 2,1,2,1.
// - Writing one to tx clear empties tx FIFO, level zero, write pointer reset.
// - Tx interrupt on reaching threshold; optionally also when take leaves level below.
// - Tx threshold codes: empty,1,2,3 bytes; full duplex empty,1,empty,1.
// - FIFO enabled: 4 bytes one direction, or 2 plus 2 in full duplex.
// - Fill levels report 000 empty and 001 to 100 for one to four bytes.
`timescale 1ns/10ps
module sft_ctrl #(
    parameter int DATA_W = 32 // Register data width
) (
    input  wire logic              clk,        // System clock, 200 MHz
    input  wire logic              rst,        // Synchronous reset, high
    input  wire logic [7:0]        addr,       // Register byte address
    input  wire logic [DATA_W-1:0] wdata,      // Register write data
    input  wire logic              wr,         // Write strobe
    input  wire logic              rd,         // Read strobe
    output logic      [DATA_W-1:0] rdata,      // Read data, one cycle later
    input  wire logic              rx_push,    // Received byte valid
    input  wire logic [7:0]        rx_byte,    // Received byte
    input  wire logic              rx_pop,     // Software reads a byte
    output logic      [7:0]        rx_head,    // Byte handed to reader
    input  wire logic              tx_push,    // Software writes a byte
    input  wire logic [7:0]        tx_byte,    // Byte to send
    input  wire logic              tx_pop,     // Engine takes a byte
    output logic      [7:0]        tx_head,    // Byte handed to engine
    output logic                   rx_full,    // Rx FIFO at capacity
    output logic                   tx_full,    // Tx FIFO at capacity
    output logic                   rx_req,     // Rx interrupt request pulse
    output logic                   tx_req,     // Tx interrupt request pulse
    output logic                   irq         // Level interrupt, masked status
);
    // Field layout is fixed to a 32-bit register word
    if (DATA_W != 32)
    begin : g_width_check
        $error("sft_ctrl: DATA_W must be 32");
    end

    sft_fifo_if rxf ();
    sft_fifo_if txf ();

    logic [1:0] rx_thr_reg;
    logic       rx_cond_reg;
    logic [1:0] tx_thr_reg;
    logic       tx_cond_reg;
    logic [4:0] ctrl_reg;
    logic [1:0] irq_st_reg;
    logic [1:0] irq_msk_reg;
    logic [2:0] rx_lvl_q_reg;
    logic [2:0] tx_lvl_q_reg;
    logic [7:0] rx_head_reg;
    logic [7:0] tx_head_reg;
    logic       rx_full_reg;
    logic       tx_full_reg;
    logic       rx_req_reg;
    logic       tx_req_reg;
    logic       irq_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic       rx_hit;
    logic       tx_hit;
    logic [2:0] rx_thr_bytes;
    logic [2:0] tx_thr_bytes;
    logic       fifo_on;
    logic       full_dup;

    // ==========================================================
    // Decode helpers
    // ==========================================================
    // Rx threshold code to byte count
    function automatic logic [2:0] rx_thr_decode(input logic [1:0] code, input logic fd);
        logic [2:0] r;
        r = 3'h0;
        if (fd)
            r = code[0] ? 3'h1 : 3'h2;
        else
            r = (code == 2'h0) ? 3'h4 : {1'b0, code};
        return r;
    endfunction

    // Tx threshold code to byte count
    function automatic logic [2:0] tx_thr_decode(input logic [1:0] code, input logic fd);
        logic [2:0] r;
        r = 3'h0;
        if (fd)
            r = {2'h0, code[0]};
        else
            r = {1'b0, code};
        return r;
    endfunction

    // Capacity of one direction for the present configuration
    function automatic logic [2:0] capacity(input logic on, input logic fd, input logic mine);
        logic [2:0] r;
        r = 3'h0;
        if (on && fd)
            r = 3'(sft_pkg::SFT_HALF_DEPTH);
        else if (on && mine)
            r = 3'(sft_pkg::SFT_DEPTH);
        else
            r = 3'h1;
        return r;
    endfunction

    assign fifo_on  = ctrl_reg[sft_pkg::SFT_FIFO_EN];
    assign full_dup = ctrl_reg[sft_pkg::SFT_DUPLEX_BIT];
    assign rx_thr_bytes = rx_thr_decode(rx_thr_reg, full_dup);
    assign tx_thr_bytes = tx_thr_decode(tx_thr_reg, full_dup);

    // ==========================================================
    // FIFO connections
    // ==========================================================
    assign rxf.push  = rx_push;
    assign rxf.pop   = rx_pop;
    assign rxf.wdata = rx_byte;
    assign rxf.cap   = capacity(fifo_on, full_dup, ctrl_reg[sft_pkg::SFT_RXHALF_BIT]);
    assign rxf.clear = wr && (addr == sft_pkg::SFT_RXCFG_OFS)
                       && wdata[sft_pkg::SFT_CLEAR_BIT];
    assign txf.push  = tx_push;
    assign txf.pop   = tx_pop;
    assign txf.wdata = tx_byte;
    assign txf.cap   = capacity(fifo_on, full_dup, !ctrl_reg[sft_pkg::SFT_RXHALF_BIT]);
    assign txf.clear = wr && (addr == sft_pkg::SFT_TXCFG_OFS)
                       && wdata[sft_pkg::SFT_CLEAR_BIT];

    sft_fifo #(
        .DEPTH (sft_pkg::SFT_DEPTH)
    ) u_rx_fifo (
        .clk  (clk),
        .rst  (rst),
        .port (rxf.fifo)
    );

    sft_fifo #(
        .DEPTH (sft_pkg::SFT_DEPTH)
    ) u_tx_fifo (
        .clk  (clk),
        .rst  (rst),
        .port (txf.fifo)
    );

    // ==========================================================
    // Threshold event detection
    // ==========================================================
    // Rx: level arrives at threshold, or a read leaves it above threshold
    always_comb
    begin
        rx_hit = (rxf.level == rx_thr_bytes) && (rx_lvl_q_reg != rx_thr_bytes)
                 && !rx_lvl_q_reg[2] && (rxf.level > rx_lvl_q_reg);
        if (rx_cond_reg && rx_lvl_q_reg > rxf.level && rxf.level > rx_thr_bytes)
            rx_hit = 1'b1;
        if (rxf.level == rx_thr_bytes && rxf.level > rx_lvl_q_reg)
            rx_hit = 1'b1;
    end

    // Tx: level drains to threshold, or a take leaves it short of threshold
    always_comb
    begin
        tx_hit = (txf.level == tx_thr_bytes) && (tx_lvl_q_reg > txf.level);
        if (tx_cond_reg && (tx_lvl_q_reg > txf.level) && (txf.level < tx_thr_bytes))
            tx_hit = 1'b1;
    end

    // Previous levels for edge detection; they follow the FIFO levels
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_lvl_q_reg <= sft_pkg::SFT_LVL_EMPTY;
            tx_lvl_q_reg <= sft_pkg::SFT_LVL_EMPTY;
        end
        else
        begin
            rx_lvl_q_reg <= rxf.level;
            tx_lvl_q_reg <= txf.level;
        end
    end

    // One-cycle requests, only with the direction's interrupt enabled
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_req_reg <= 1'b0;
            tx_req_reg <= 1'b0;
        end
        else
        begin
            rx_req_reg <= rx_hit && ctrl_reg[sft_pkg::SFT_RXIE_BIT]
                          && !rxf.clear;
            tx_req_reg <= tx_hit && ctrl_reg[sft_pkg::SFT_TXIE_BIT]
                          && !txf.clear;
        end
    end

    // ==========================================================
    // Configuration registers
    // ==========================================================
    // Threshold and condition fields; clear bits are write-only and not stored
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_thr_reg  <= sft_pkg::SFT_THR_RESET;
            rx_cond_reg <= 1'b0;
            tx_thr_reg  <= sft_pkg::SFT_THR_RESET;
            tx_cond_reg <= 1'b0;
        end
        else if (wr && addr == sft_pkg::SFT_RXCFG_OFS)
        begin
            rx_thr_reg  <= wdata[1:0];
            rx_cond_reg <= wdata[sft_pkg::SFT_COND_BIT];
        end
        else if (wr && addr == sft_pkg::SFT_TXCFG_OFS)
        begin
            tx_thr_reg  <= wdata[1:0];
            tx_cond_reg <= wdata[sft_pkg::SFT_COND_BIT];
        end
    end

    // FIFO enable, duplex, interrupt enables and half-duplex direction
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_reg <= sft_pkg::SFT_CTRL_RESET;
        else if (wr && addr == sft_pkg::SFT_CTRL_OFS)
            ctrl_reg <= wdata[4:0];
    end

    // ==========================================================
    // Interrupt status and mask
    // ==========================================================
    // Sticky status; a new event in the read cycle wins over the clear
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_st_reg <= sft_pkg::SFT_IRQ_RESET;
        else
        begin
            if (rd && addr == sft_pkg::SFT_IRQST_OFS)
                irq_st_reg <= {tx_req_reg, rx_req_reg};
            else
                irq_st_reg <= irq_st_reg | {tx_req_reg, rx_req_reg};
        end
    end

    // Mask register
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_msk_reg <= sft_pkg::SFT_IRQ_RESET;
        else if (wr && addr == sft_pkg::SFT_IRQMSK_OFS)
            irq_msk_reg <= wdata[1:0];
    end

    // Level output registered from status and mask
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_reg <= 1'b0;
        else
            irq_reg <= |(irq_st_reg & irq_msk_reg);
    end

    // ==========================================================
    // Read port
    // ==========================================================
    // Address decode; unmapped and write-only bits read as zero
    always_comb
    begin
        rdata_next = '0;
        if (addr == sft_pkg::SFT_RXCFG_OFS)
            rdata_next[6:0] = {rx_cond_reg, 4'h0, rx_thr_reg};
        else if (addr == sft_pkg::SFT_TXCFG_OFS)
            rdata_next[6:0] = {tx_cond_reg, 4'h0, tx_thr_reg};
        else if (addr == sft_pkg::SFT_CTRL_OFS)
            rdata_next[4:0] = ctrl_reg;
        else if (addr == sft_pkg::SFT_LEVEL_OFS)
        begin
            rdata_next[2:0]   = rxf.level;
            rdata_next[sft_pkg::SFT_TXLVL_LSB +: 3] = txf.level;
        end
        else if (addr == sft_pkg::SFT_IRQST_OFS)
            rdata_next[1:0] = irq_st_reg;
        else if (addr == sft_pkg::SFT_IRQMSK_OFS)
            rdata_next[1:0] = irq_msk_reg;
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata_reg <= '0;
        else if (rd)
            rdata_reg <= rdata_next;
        else
            rdata_reg <= '0;
    end

    // ==========================================================
    // Data path outputs
    // ==========================================================
    // Registered heads and full flags
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_head_reg <= 8'h00;
            tx_head_reg <= 8'h00;
            rx_full_reg <= 1'b0;
            tx_full_reg <= 1'b0;
        end
        else
        begin
            rx_head_reg <= rxf.rdata;
            tx_head_reg <= txf.rdata;
            rx_full_reg <= (rxf.level >= rxf.cap);
            tx_full_reg <= (txf.level >= txf.cap);
        end
    end

    assign rdata   = rdata_reg;
    assign rx_head = rx_head_reg;
    assign tx_head = tx_head_reg;
    assign rx_full = rx_full_reg;
    assign tx_full = tx_full_reg;
    assign rx_req  = rx_req_reg;
    assign tx_req  = tx_req_reg;
    assign irq     = irq_reg;
endmodule

//--- inc/sft_pkg.sv
/*
 * Shared constants of the serial FIFO threshold control: register offsets,
 * field positions, reset values and FIFO sizes.
 * Assumes a 32-bit register port with byte addresses, one word per register.
 */
package sft_pkg;

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] SFT_RXCFG_OFS  = 8'h00;
    localparam logic [7:0] SFT_TXCFG_OFS  = 8'h04;
    localparam logic [7:0] SFT_CTRL_OFS   = 8'h08;
    localparam logic [7:0] SFT_LEVEL_OFS  = 8'h0C;
    localparam logic [7:0] SFT_IRQST_OFS  = 8'h10;
    localparam logic [7:0] SFT_IRQMSK_OFS = 8'h14;

    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int SFT_CLEAR_BIT  = 7;
    localparam int SFT_COND_BIT   = 6;
    localparam int SFT_FIFO_EN    = 0;
    localparam int SFT_DUPLEX_BIT = 1;
    localparam int SFT_RXIE_BIT   = 2;
    localparam int SFT_TXIE_BIT   = 3;
    localparam int SFT_RXHALF_BIT = 4;
    localparam int SFT_TXLVL_LSB  = 8;

    // ==========================================================
    // Reset values and sizes
    // ==========================================================
    localparam logic [1:0]  SFT_THR_RESET  = 2'h0;
    localparam logic [2:0]  SFT_LVL_EMPTY  = 3'h0;
    localparam logic [4:0]  SFT_CTRL_RESET = 5'h00;
    localparam logic [1:0]  SFT_IRQ_RESET  = 2'h0;
    localparam int          SFT_DEPTH      = 4;
    localparam int          SFT_HALF_DEPTH = 2;

endpackage

//--- inc/sft_fifo_if.sv
/*
 * Bundle between the control core and one byte FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface sft_fifo_if;
    logic       push;     // Write one byte
    logic       pop;      // Take one byte
    logic       clear;    // Empty and reset pointers
    logic [2:0] cap;      // Present capacity in bytes
    logic [7:0] wdata;    // Byte written
    logic [7:0] rdata;    // Byte at head
    logic [2:0] level;    // Bytes held
    logic       accepted; // Push taken
    logic       taken;    // Pop taken

    modport ctrl (output push, pop, clear, cap, wdata,
                  input rdata, level, accepted, taken);
    modport fifo (input push, pop, clear, cap, wdata,
                  output rdata, level, accepted, taken);
endinterface

//--- hdl/sft_fifo.sv
/*
 * Byte FIFO of up to four entries in flip-flops, capacity set at run time.
 * Assumes push and pop from one clock domain; clear has priority.
 */
`timescale 1ns/10ps
module sft_fifo #(
    parameter int DEPTH = 4 // Storage entries
) (
    input  wire logic clk,  // System clock
    input  wire logic rst,  // Synchronous reset
    sft_fifo_if.fifo  port  // FIFO bundle
);
    // Pointers and storage are sized for four entries only
    if (DEPTH != 4)
    begin : g_depth_check
        $error("sft_fifo: DEPTH must be 4");
    end

    logic [7:0] mem_reg [DEPTH];
    logic [1:0] wptr_reg;
    logic [1:0] rptr_reg;
    logic [2:0] cnt_reg;
    logic       do_push;
    logic       do_pop;

    // ==========================================================
    // Accept logic
    // ==========================================================
    assign do_pop       = port.pop && (cnt_reg != 3'h0);
    assign do_push      = port.push && ((cnt_reg < port.cap) || do_pop);
    assign port.accepted = do_push && !port.clear;
    assign port.taken    = do_pop && !port.clear;
    assign port.level    = cnt_reg;
    assign port.rdata    = mem_reg[rptr_reg];

    // Pointers and count; clear empties and reinitialises both pointers
    always_ff @(posedge clk)
    begin
        if (rst || port.clear)
        begin
            wptr_reg <= 2'h0;
            rptr_reg <= 2'h0;
            cnt_reg  <= 3'h0;
        end
        else
        begin
            if (do_push)
                wptr_reg <= (wptr_reg + 2'h1 == port.cap[1:0]) && (port.cap != 3'h4)
                            ? 2'h0 : wptr_reg + 2'h1;
            if (do_pop)
                rptr_reg <= (rptr_reg + 2'h1 == port.cap[1:0]) && (port.cap != 3'h4)
                            ? 2'h0 : rptr_reg + 2'h1;
            cnt_reg <= cnt_reg + {2'h0, do_push} - {2'h0, do_pop};
        end
    end

    // Storage
    always_ff @(posedge clk)
    begin
        if (do_push)
            mem_reg[wptr_reg] <= port.wdata;
    end
endmodule

//--- test/sft_ctrl_chk.sv
/*
 * Port checker of the FIFO threshold control.
 * Assumes a bind into sft_ctrl, one clock and a synchronous reset.
 */
`timescale 1ns/10ps
module sft_ctrl_chk #(
    parameter int DATA_W = 32 // Register data width
) (
    input wire logic              clk,     // Clock
    input wire logic              rst,     // Reset
    input wire logic [7:0]        addr,    // Address
    input wire logic [DATA_W-1:0] wdata,   // Write data
    input wire logic              wr,      // Write strobe
    input wire logic              rd,      // Read strobe
    input wire logic [DATA_W-1:0] rdata,   // Read data
    input wire logic              rx_push, // Rx push
    input wire logic              rx_pop,  // Rx pop
    input wire logic              tx_push, // Tx push
    input wire logic              tx_pop,  // Tx pop
    input wire logic              rx_full, // Rx full
    input wire logic              tx_full, // Tx full
    input wire logic              rx_req,  // Rx request
    input wire logic              tx_req,  // Tx request
    input wire logic              irq      // Interrupt
);
    // ==========================================================
    // Sequences
    // ==========================================================
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Clear write, then two cycles without a push
    sequence s_rx_clr;
        wr && addr == sft_pkg::SFT_RXCFG_OFS && wdata[sft_pkg::SFT_CLEAR_BIT] ##1 !rx_push [*2];
    endsequence
    sequence s_tx_clr;
        wr && addr == sft_pkg::SFT_TXCFG_OFS && wdata[sft_pkg::SFT_CLEAR_BIT] ##1 !tx_push [*2];
    endsequence
    // Status read with no new event beside it
    sequence s_st_rd;
        rd && addr == sft_pkg::SFT_IRQST_OFS && !rx_req && !tx_req;
    endsequence

    // ==========================================================
    // Assertions
    // ==========================================================
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == '0)
        else $error("read data not zero outside a read answer");
    AST_UNMAPPED_ZERO: assert property (rd && addr == 8'h20 |=> rdata == '0)
        else $error("unmapped read not zero");
    AST_CFG_READ: assert property (rd && (addr == sft_pkg::SFT_RXCFG_OFS ||
        addr == sft_pkg::SFT_TXCFG_OFS) |=> rdata[DATA_W-1:7] == '0 && rdata[5:2] == '0)
        else $error("config read shows clear or reserved bits");
    AST_RX_REQ_CAUSE: assert property (rx_req |-> $past(rx_push, 2) ||
        $past(rx_pop, 2) || $past(wr, 2))
        else $error("rx request without cause");
    AST_TX_REQ_CAUSE: assert property (tx_req |-> $past(tx_push, 2) ||
        $past(tx_pop, 2) || $past(wr, 2))
        else $error("tx request without cause");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(rx_req, 2) ||
        $past(tx_req, 2) || $past(wr) || $past(wr, 2))
        else $error("interrupt rose without event");
    AST_IRQ_CLEAR: assert property (s_st_rd |-> ##2 !irq)
        else $error("interrupt stays after status read");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(rd, 2) || $past(wr) ||
        $past(wr, 2))
        else $error("interrupt fell without read or write");
    AST_RX_FULL_CLEAR: assert property (s_rx_clr |=> !rx_full)
        else $error("rx full after clear");
    AST_TX_FULL_CLEAR: assert property (s_tx_clr |=> !tx_full)
        else $error("tx full after clear");
endmodule

//--- test/sft_ctrl_tb_top.sv
/*
 * Self-checking bench of the FIFO threshold control.
 * Assumes the package, design and checker are compiled before it.
 */
`timescale 1ns/10ps
module sft_ctrl_tb_top;
    // ==========================================================
    // Signals
    // ==========================================================
    logic        clk, rst, wr, rd, rx_push, rx_pop, tx_push, tx_pop;
    logic        rx_full, tx_full, rx_req, tx_req, irq;
    logic [7:0]  addr, byte_q, rx_head, tx_head;
    logic [31:0] wdata, rdata;
    int          err_count, checks, rx_cnt, tx_cnt;
    int          rx_thr [2][4] = '{'{4, 1, 2, 3}, '{2, 1, 2, 1}};
    int          tx_thr [2][4] = '{'{0, 1, 2, 3}, '{0, 1, 0, 1}};
    logic [7:0]  ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};

    sft_ctrl #(.DATA_W(32)) u_dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .rx_push(rx_push), .rx_byte(byte_q), .rx_pop(rx_pop), .rx_head(rx_head),
        .tx_push(tx_push), .tx_byte(byte_q), .tx_pop(tx_pop), .tx_head(tx_head),
        .rx_full(rx_full), .tx_full(tx_full), .rx_req(rx_req), .tx_req(tx_req), .irq(irq));

    // Clock of 5 ns
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Count request pulses
    always @(posedge clk)
    begin
        rx_cnt += (rx_req === 1'b1);
        tx_cnt += (tx_req === 1'b1);
    end

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    // One strobe of {tx_pop, tx_push, rx_pop, rx_push}, then let the request land
    task automatic pulse(input logic [3:0] sel);
        @(posedge clk);
        {tx_pop, tx_push, rx_pop, rx_push} <= sel;
        @(posedge clk);
        {tx_pop, tx_push, rx_pop, rx_push} <= 4'h0;
        byte_q <= byte_q + 8'h01;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic setup(input logic [7:0] ctl, input logic [7:0] rxc, input logic [7:0] txc);
        logic [31:0] v;
        wr_reg(sft_pkg::SFT_CTRL_OFS, {24'h0, ctl});
        wr_reg(sft_pkg::SFT_RXCFG_OFS, {24'h0, rxc | 8'h80});
        wr_reg(sft_pkg::SFT_TXCFG_OFS, {24'h0, txc | 8'h80});
        rd_reg(sft_pkg::SFT_IRQST_OFS, v);
        byte_q <= 8'hA0;
        rx_cnt = 0;
        tx_cnt = 0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    // Main sequence
    initial
    begin
        logic [31:0] v;
        int          hit;
        int          cap;
        {rst, wr, rd, rx_push, rx_pop, tx_push, tx_pop} = 7'h40;
        {addr, wdata, byte_q} = '0;
        {err_count, checks, rx_cnt, tx_cnt} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i])
        begin
            rd_reg(ofs[i], v);
            chk(v, 32'h0, "reset value");
        end
        wr_reg(sft_pkg::SFT_RXCFG_OFS, 32'hFFFF_FFFF);
        wr_reg(sft_pkg::SFT_TXCFG_OFS, 32'hFFFF_FFFF);
        wr_reg(8'h20, 32'hFFFF_FFFF);
        rd_reg(sft_pkg::SFT_RXCFG_OFS, v);
        chk(v, 32'h43, "rx config readback");
        rd_reg(sft_pkg::SFT_TXCFG_OFS, v);
        chk(v, 32'h43, "tx config readback");
        rd_reg(8'h20, v);
        chk(v, 32'h0, "unmapped read");
        $display("test registers done");
        // Every threshold code in both duplex settings
        for (int d = 0; d < 2; d++)
            for (int c = 0; c < 4; c++)
            begin
                cap = d ? 2 : 4;
                setup(d ? 8'h07 : 8'h15, 8'(c), 8'h00);
                hit = 0;
                for (int n = 1; n <= cap + 1; n++)
                begin
                    pulse(4'h1);
                    if (rx_cnt > 0 && hit == 0)
                        hit = n;
                end
                chk(32'(hit), 32'(rx_thr[d][c]), "rx threshold");
                rd_reg(sft_pkg::SFT_LEVEL_OFS, v);
                chk(v, 32'(cap), "rx level at capacity");
                chk({31'h0, rx_full}, 32'h1, "rx full");
                chk({24'h0, rx_head}, 32'hA0, "rx head order");
                setup(d ? 8'h0B : 8'h09, 8'h00, 8'(c));
                repeat (cap) pulse(4'h4);
                chk({31'h0, tx_full}, 32'h1, "tx full");
                chk({24'h0, tx_head}, 32'hA0, "tx head order");
                tx_cnt = 0;
                hit = 9;
                for (int n = 1; n <= cap; n++)
                begin
                    pulse(4'h8);
                    if (tx_cnt > 0 && hit == 9)
                        hit = cap - n;
                end
                chk(32'(hit), 32'(tx_thr[d][c]), "tx threshold");
            end
        $display("test thresholds done");
        // Interrupt conditions
        for (int c = 0; c < 2; c++)
        begin
            setup(8'h15, c ? 8'h41 : 8'h01, 8'h00);
            repeat (3) pulse(4'h1);
            pulse(4'h2);
            chk(32'(rx_cnt), c ? 32'h2 : 32'h1, "rx condition");
            setup(8'h09, 8'h00, c ? 8'h42 : 8'h02);
            repeat (4) pulse(4'h4);
            tx_cnt = 0;
            repeat (4) pulse(4'h8);
            chk(32'(tx_cnt), c ? 32'h3 : 32'h1, "tx condition");
        end
        $display("test conditions done");
        // Clear of both FIFOs
        setup(8'h15, 8'h00, 8'h00);
        repeat (4) pulse(4'h1);
        repeat (2) pulse(4'h4);
        rd_reg(sft_pkg::SFT_LEVEL_OFS, v);
        chk(v, 32'h0000_0104, "levels before clear");
        wr_reg(sft_pkg::SFT_RXCFG_OFS, 32'h80);
        wr_reg(sft_pkg::SFT_TXCFG_OFS, 32'h80);
        rd_reg(sft_pkg::SFT_LEVEL_OFS, v);
        chk(v, 32'h0, "levels after clear");
        chk({30'h0, tx_full, rx_full}, 32'h0, "full flags after clear");
        $display("test clear done");
        // Enable, mask, status and interrupt line
        setup(8'h11, 8'h01, 8'h00);
        pulse(4'h1);
        chk(32'(rx_cnt), 32'h0, "request while disabled");
        setup(8'h15, 8'h01, 8'h00);
        wr_reg(sft_pkg::SFT_IRQMSK_OFS, 32'h0);
        pulse(4'h1);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0, "masked interrupt");
        rd_reg(sft_pkg::SFT_IRQST_OFS, v);
        chk(v, 32'h1, "rx status set");
        rd_reg(sft_pkg::SFT_IRQST_OFS, v);
        chk(v, 32'h0, "status cleared by read");
        wr_reg(sft_pkg::SFT_RXCFG_OFS, 32'h81);
        wr_reg(sft_pkg::SFT_IRQMSK_OFS, 32'h3);
        pulse(4'h1);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h1, "interrupt raised");
        rd_reg(sft_pkg::SFT_IRQST_OFS, v);
        @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0, "interrupt cleared");
        $display("test interrupts done");
        report_and_stop();
    end
endmodule

bind sft_ctrl sft_ctrl_chk #(.DATA_W(DATA_W)) u_chk (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_push(rx_push), .rx_pop(rx_pop), .tx_push(tx_push), .tx_pop(tx_pop),
    .rx_full(rx_full), .tx_full(tx_full), .rx_req(rx_req), .tx_req(tx_req), .irq(irq));
